// ==== src/bcc_pkg.sv ====
package bcc_pkg;
    // Register byte addresses (chosen)
    localparam logic [11:0] ADDR_CONFIG = 12'h000;
    localparam logic [11:0] ADDR_TIME_VALUE = 12'h004;
    localparam logic [11:0] ADDR_ALARM_CONFIG = 12'h008;
    localparam logic [11:0] ADDR_ALARM_VALUE = 12'h00c;
    localparam logic [11:0] ADDR_UNLOCK_KEY = 12'h010;
    localparam logic [11:0] ADDR_TICK_CTRL = 12'h014;
    // Config register fields
    localparam int CFG_ENABLE_BIT = 15;
    localparam int CFG_UNLOCK_BIT = 13;
    localparam int CFG_PENDING_BIT = 12;
    localparam int CFG_PTR_LO = 8;
    // Alarm config fields
    localparam int ACFG_ENABLE_BIT = 15;
    localparam int ACFG_PTR_LO = 8;
    // Unlock keys
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    // Window pointer codes
    localparam logic [1:0] PTR_MIN_SEC = 2'h0;
    localparam logic [1:0] PTR_WEEKDAY_DIGIT_HOUR = 2'h1;
    localparam logic [1:0] PTR_MONTH_DAY = 2'h2;
    localparam logic [1:0] PTR_YEAR = 2'h3;
    // Field masks of value windows
    localparam logic [15:0] MASK_YEAR = 16'h00ff;
    localparam logic [15:0] MASK_MONTH_DAY = 16'h1f3f;
    localparam logic [15:0] MASK_WEEKDAY_DIGIT_HOUR = 16'h073f;
    localparam logic [15:0] MASK_MIN_SEC = 16'h7f7f;
    // Crystal and timing
    localparam int XTAL_HZ = 32768;
    localparam int TICK_HZ = 1;
    localparam int XTAL_PER_TICK = XTAL_HZ / TICK_HZ;
    localparam int PENDING_EDGES = 32;
    localparam logic [14:0] PRESCALE_LAST = 15'(XTAL_PER_TICK - 1);
    localparam logic [14:0] PENDING_START = 15'(XTAL_PER_TICK - PENDING_EDGES);
    // Counter limits, BCD
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_23 = 8'h23;
    localparam logic [7:0] BCD_6 = 8'h06;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam logic [7:0] BCD_1 = 8'h01;
    localparam logic [7:0] BCD_0 = 8'h00;
    localparam logic [7:0] BCD_28 = 8'h28;
    localparam logic [7:0] BCD_29 = 8'h29;
    localparam logic [7:0] BCD_30 = 8'h30;
    localparam logic [7:0] BCD_31 = 8'h31;
    localparam logic [7:0] BCD_FEB = 8'h02;
    localparam logic [7:0] BCD_APR = 8'h04;
    localparam logic [7:0] BCD_JUN = 8'h06;
    localparam logic [7:0] BCD_SEP = 8'h09;
    localparam logic [7:0] BCD_NOV = 8'h11;
    // AHB constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} bcc_key_state_t;
endpackage : bcc_pkg

// ==== src/bcc_core.sv ====
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module bcc_core (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic xtal_tick,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic alarm_event
);
    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [7:0] sec_r;
    logic [7:0] min_r;
    logic [7:0] hour_r;
    logic [7:0] weekday_digit_r;
    logic [7:0] day_r;
    logic [7:0] month_r;
    logic [7:0] year_r;
    logic [14:0] prescale_r;
    logic pending_r;
    logic enable_r;
    logic unlock_r;
    logic [1:0] tptr_r;
    logic [1:0] aptr_r;
    logic [1:0] tptr_wr_r;
    logic [1:0] aptr_wr_r;
    logic tick_d_r;
    logic alarm_en_r;
    logic [15:0] al_md_r;
    logic [15:0] al_wh_r;
    logic [15:0] al_ms_r;
    bcc_pkg::bcc_key_state_t key_r;
    logic [31:0] rdata_nxt;
    logic [15:0] wval;
    logic tick;
    logic addr_ok;
    logic wr_cfg;
    logic wr_time;
    logic wr_acfg;
    logic wr_alarm;
    logic wr_key;
    logic tstep;
    logic astep;
    logic [7:0] month_len;
    logic leap;
    logic [15:0] tv_nxt;

    // Carry-aware BCD increment with wrap
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
        logic [7:0] r;
        r = v;
        if (v == last) begin
            r = first;
        end else if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction : bcd_inc

    function automatic logic [15:0] time_window(input logic [1:0] p, input logic [7:0] s,
        input logic [7:0] m, input logic [7:0] h, input logic [7:0] w, input logic [7:0] d,
        input logic [7:0] mo, input logic [7:0] y);
        logic [15:0] r;
        r = 16'h0000;
        case (p)
            bcc_pkg::PTR_YEAR: r = {8'h00, y} & bcc_pkg::MASK_YEAR;
            bcc_pkg::PTR_MONTH_DAY: r = {mo, d} & bcc_pkg::MASK_MONTH_DAY;
            bcc_pkg::PTR_WEEKDAY_DIGIT_HOUR: r = {w, h} & bcc_pkg::MASK_WEEKDAY_DIGIT_HOUR;
            default: r = {m, s} & bcc_pkg::MASK_MIN_SEC;
        endcase
        return r;
    endfunction : time_window

    // Halfword or word access to a value window steps its pointer down, holding at zero
    function automatic logic win_step(input logic ok, input logic [2:0] sz,
                                      input logic [11:0] a, input logic [11:0] win,
                                      input logic [1:0] p);
        return ok && sz != 3'h0 && a == win && p != bcc_pkg::PTR_MIN_SEC;
    endfunction : win_step

    assign addr_ok = hsel && hready && (htrans == bcc_pkg::HTRANS_NONSEQ ||
                     htrans == bcc_pkg::HTRANS_SEQ);
    assign wval = hwdata[15:0];
    assign tstep = win_step(addr_ok, hsize, haddr[11:0], bcc_pkg::ADDR_TIME_VALUE, tptr_r);
    assign astep = win_step(addr_ok, hsize, haddr[11:0], bcc_pkg::ADDR_ALARM_VALUE, aptr_r);
    assign tv_nxt = time_window(tptr_r, sec_r, min_r, hour_r, weekday_digit_r, day_r, month_r, year_r);
    assign wr_cfg = wr_pend_r && wr_addr_r == bcc_pkg::ADDR_CONFIG;
    assign wr_time = wr_pend_r && wr_addr_r == bcc_pkg::ADDR_TIME_VALUE;
    assign wr_acfg = wr_pend_r && wr_addr_r == bcc_pkg::ADDR_ALARM_CONFIG;
    assign wr_alarm = wr_pend_r && wr_addr_r == bcc_pkg::ADDR_ALARM_VALUE;
    assign wr_key = wr_pend_r && wr_addr_r == bcc_pkg::ADDR_UNLOCK_KEY;
    assign tick = enable_r && xtal_tick && prescale_r == bcc_pkg::PRESCALE_LAST;
    // BCD year divisible by four; year 00 counts as leap
    assign leap = (year_r[4] == 1'b0 && year_r[1:0] == 2'b00) ||
                  (year_r[4] == 1'b1 && year_r[1:0] == 2'b10);

    // Month length in BCD
    always_comb begin
        if (month_r == bcc_pkg::BCD_FEB) begin
            month_len = leap ? bcc_pkg::BCD_29 : bcc_pkg::BCD_28;
        end else if (month_r == bcc_pkg::BCD_APR || month_r == bcc_pkg::BCD_JUN ||
                     month_r == bcc_pkg::BCD_SEP || month_r == bcc_pkg::BCD_NOV) begin
            month_len = bcc_pkg::BCD_30;
        end else begin
            month_len = bcc_pkg::BCD_31;
        end
    end

    // Write data phase latch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else if (hready) begin
            wr_pend_r <= addr_ok && hwrite;
            wr_addr_r <= haddr[11:0];
        end
    end

    // Bus reads, registered one cycle after the address phase
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (haddr[11:0] == bcc_pkg::ADDR_CONFIG) begin
            rdata_nxt[bcc_pkg::CFG_ENABLE_BIT] = enable_r;
            rdata_nxt[bcc_pkg::CFG_UNLOCK_BIT] = unlock_r;
            rdata_nxt[bcc_pkg::CFG_PENDING_BIT] = pending_r;
            rdata_nxt[bcc_pkg::CFG_PTR_LO +: 2] = tptr_r;
        end else if (haddr[11:0] == bcc_pkg::ADDR_TIME_VALUE) begin
            rdata_nxt[15:0] = tv_nxt;
        end else if (haddr[11:0] == bcc_pkg::ADDR_ALARM_CONFIG) begin
            rdata_nxt[bcc_pkg::ACFG_ENABLE_BIT] = alarm_en_r;
            rdata_nxt[bcc_pkg::ACFG_PTR_LO +: 2] = aptr_r;
        end else if (haddr[11:0] == bcc_pkg::ADDR_ALARM_VALUE) begin
            if (aptr_r == bcc_pkg::PTR_MONTH_DAY) begin
                rdata_nxt[15:0] = al_md_r;
            end else if (aptr_r == bcc_pkg::PTR_WEEKDAY_DIGIT_HOUR) begin
                rdata_nxt[15:0] = al_wh_r;
            end else if (aptr_r == bcc_pkg::PTR_MIN_SEC) begin
                rdata_nxt[15:0] = al_ms_r;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rdata_nxt;
        end
    end

    // Zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Unlock key sequence; arm lasts one following write only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_r <= bcc_pkg::KEY_IDLE;
        end else if (wr_pend_r) begin
            case (key_r)
                bcc_pkg::KEY_IDLE: begin
                    if (wr_key && wval[7:0] == bcc_pkg::KEY_FIRST) begin
                        key_r <= bcc_pkg::KEY_GOT_FIRST;
                    end
                end
                bcc_pkg::KEY_GOT_FIRST: begin
                    if (wr_key && wval[7:0] == bcc_pkg::KEY_SECOND) begin
                        key_r <= bcc_pkg::KEY_ARMED;
                    end else if (wr_key && wval[7:0] == bcc_pkg::KEY_FIRST) begin
                        key_r <= bcc_pkg::KEY_GOT_FIRST;
                    end else begin
                        key_r <= bcc_pkg::KEY_IDLE;
                    end
                end
                default: begin
                    if (wr_key && wval[7:0] == bcc_pkg::KEY_FIRST) begin
                        key_r <= bcc_pkg::KEY_GOT_FIRST;
                    end else begin
                        key_r <= bcc_pkg::KEY_IDLE;
                    end
                end
            endcase
        end
    end

    // Configuration: unlock and module enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unlock_r <= 1'b0;
            enable_r <= 1'b0;
        end else if (wr_cfg) begin
            if (!wval[bcc_pkg::CFG_UNLOCK_BIT]) begin
                unlock_r <= 1'b0;
            end else if (key_r == bcc_pkg::KEY_ARMED) begin
                unlock_r <= 1'b1;
            end
            if (unlock_r) begin
                enable_r <= wval[bcc_pkg::CFG_ENABLE_BIT];
            end
        end
    end

    // Time window pointer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tptr_r <= bcc_pkg::PTR_MIN_SEC;
        end else if (wr_cfg) begin
            tptr_r <= wval[bcc_pkg::CFG_PTR_LO +: 2];
        end else if (tstep) begin
            tptr_r <= tptr_r - 2'h1;
        end
    end

    // Time window pointer as seen at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tptr_wr_r <= bcc_pkg::PTR_MIN_SEC;
        end else if (addr_ok) begin
            tptr_wr_r <= tptr_r;
        end
    end

    // Prescaler and pending flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale_r <= 15'h0000;
            pending_r <= 1'b0;
        end else if (wr_time && unlock_r && tptr_wr_r == bcc_pkg::PTR_MIN_SEC) begin
            prescale_r <= 15'h0000;
            pending_r <= 1'b0;
        end else if (enable_r && xtal_tick) begin
            prescale_r <= (prescale_r == bcc_pkg::PRESCALE_LAST) ? 15'h0000
                                                                 : prescale_r + 15'h0001;
            pending_r <= prescale_r >= bcc_pkg::PENDING_START - 15'h0001 &&
                         prescale_r != bcc_pkg::PRESCALE_LAST;
        end
    end

    // Calendar counters, no reset contents
    always_ff @(posedge hclk) begin
        if (wr_time && unlock_r) begin
            case (tptr_wr_r)
                bcc_pkg::PTR_YEAR: year_r <= wval[7:0];
                bcc_pkg::PTR_MONTH_DAY: begin
                    month_r <= {3'h0, wval[12:8]};
                    day_r <= {2'h0, wval[5:0]};
                end
                bcc_pkg::PTR_WEEKDAY_DIGIT_HOUR: begin
                    weekday_digit_r <= {5'h00, wval[10:8]};
                    hour_r <= {2'h0, wval[5:0]};
                end
                default: begin
                    min_r <= {1'b0, wval[14:8]};
                    sec_r <= {1'b0, wval[6:0]};
                end
            endcase
        end else if (tick) begin
            sec_r <= bcd_inc(sec_r, bcc_pkg::BCD_59, bcc_pkg::BCD_0);
            if (sec_r == bcc_pkg::BCD_59) begin
                min_r <= bcd_inc(min_r, bcc_pkg::BCD_59, bcc_pkg::BCD_0);
                if (min_r == bcc_pkg::BCD_59) begin
                    hour_r <= bcd_inc(hour_r, bcc_pkg::BCD_23, bcc_pkg::BCD_0);
                    if (hour_r == bcc_pkg::BCD_23) begin
                        weekday_digit_r <= bcd_inc(weekday_digit_r, bcc_pkg::BCD_6, bcc_pkg::BCD_0);
                        day_r <= bcd_inc(day_r, month_len, bcc_pkg::BCD_1);
                        if (day_r == month_len) begin
                            month_r <= bcd_inc(month_r, bcc_pkg::BCD_12, bcc_pkg::BCD_1);
                            if (month_r == bcc_pkg::BCD_12) begin
                                year_r <= bcd_inc(year_r, bcc_pkg::BCD_99, bcc_pkg::BCD_0);
                            end
                        end
                    end
                end
            end
        end
    end

    // Alarm configuration and pointer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_en_r <= 1'b0;
            aptr_r <= bcc_pkg::PTR_MIN_SEC;
        end else if (wr_acfg) begin
            alarm_en_r <= wval[bcc_pkg::ACFG_ENABLE_BIT];
            aptr_r <= wval[bcc_pkg::ACFG_PTR_LO +: 2];
        end else if (astep) begin
            aptr_r <= aptr_r - 2'h1;
        end
    end

    // Alarm value windows; pointer as seen at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aptr_wr_r <= bcc_pkg::PTR_MIN_SEC;
        end else if (addr_ok) begin
            aptr_wr_r <= aptr_r;
        end
    end

    always_ff @(posedge hclk) begin
        if (wr_alarm) begin
            if (aptr_wr_r == bcc_pkg::PTR_MONTH_DAY && unlock_r) begin
                al_md_r <= wval & bcc_pkg::MASK_MONTH_DAY;
            end else if (aptr_wr_r == bcc_pkg::PTR_WEEKDAY_DIGIT_HOUR) begin
                al_wh_r <= wval & bcc_pkg::MASK_WEEKDAY_DIGIT_HOUR;
            end else if (aptr_wr_r == bcc_pkg::PTR_MIN_SEC) begin
                al_ms_r <= wval & bcc_pkg::MASK_MIN_SEC;
            end
        end
    end

    // Counters settle one cycle after the tick; the new time is compared
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_d_r <= 1'b0;
        end else begin
            tick_d_r <= tick;
        end
    end

    // Alarm compare on every tick update of the counters
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_event <= 1'b0;
        end else begin
            alarm_event <= tick_d_r && alarm_en_r && al_md_r == {month_r, day_r} &&
                           al_wh_r == {weekday_digit_r, hour_r} && al_ms_r == {min_r, sec_r};
        end
    end
endmodule : bcc_core

// ==== dv/bcc_core_sva.sv ====
`timescale 1ns/1ps
module bcc_core_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic xtal_tick,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic alarm_event
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic rd_go;
    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    sequence s_rd(logic [11:0] a);
        rd_go && haddr[11:0] == a;
    endsequence
    property p_ready;
        hreadyout;
    endproperty
    property p_okay;
        !hresp;
    endproperty
    property p_alarm_rd;
        s_rd(bcc_pkg::ADDR_ALARM_VALUE) |=> hrdata[31:15] == 17'h0 && !hrdata[7];
    endproperty
    property p_time_rd;
        s_rd(bcc_pkg::ADDR_TIME_VALUE) |=> hrdata[31:15] == 17'h0;
    endproperty
    property p_unmapped;
        rd_go && haddr[11:0] > 12'h014 |=> hrdata == 32'h0;
    endproperty
    property p_hold;
        !rd_go |=> $stable(hrdata);
    endproperty
    property p_event_pulse;
        alarm_event |=> !alarm_event;
    endproperty
    property p_event_tick;
        alarm_event |-> $past(xtal_tick) || $past(xtal_tick, 2) || $past(xtal_tick, 3);
    endproperty
    a_ready: assert property (p_ready) else $error("hreadyout low");
    a_okay: assert property (p_okay) else $error("error response");
    a_alarm_rd: assert property (p_alarm_rd) else $error("alarm spare bits set");
    a_time_rd: assert property (p_time_rd) else $error("time spare bits set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_event_pulse: assert property (p_event_pulse) else $error("alarm too long");
    a_event_tick: assert property (p_event_tick) else $error("alarm off update");
    c_alarm: cover property (alarm_event);
endmodule : bcc_core_chk
bind bcc_core bcc_core_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .xtal_tick(xtal_tick), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .alarm_event(alarm_event));

// ==== dv/bcd_clock_calendar_core_test.sv ====
`timescale 1ns/1ps
module bcd_clock_calendar_core_test;
    localparam logic [11:0] CFG = bcc_pkg::ADDR_CONFIG;
    localparam logic [11:0] TV = bcc_pkg::ADDR_TIME_VALUE;
    localparam logic [11:0] ACF = bcc_pkg::ADDR_ALARM_CONFIG;
    localparam logic [11:0] AV = bcc_pkg::ADDR_ALARM_VALUE;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic xtal_tick = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic alarm_event;
    int n_errors = 0;
    int n_compared = 0;
    int n_alarms = 0;
    int seed = 32'h7dd9;
    logic [31:0] rd;
    logic [31:0] al [3];
    assign hready = hreadyout;
    always #50 hclk = ~hclk;
    bcc_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .xtal_tick(xtal_tick), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .alarm_event(alarm_event));
    always @(posedge hclk) begin
        if (alarm_event === 1'b1) n_alarms <= n_alarms + 1;
    end
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic chk_word(logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t: read %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_count(int got, int exp);
        n_compared++;
        if (got != exp) begin
            n_errors++;
            $display("BAD %0t: %0d alarms, expected %0d", $time, got, exp);
        end
    endtask : chk_count
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 50) begin
            n_errors++;
            complete_run();
        end
    endtask : wait_ready
    task automatic bus(logic wr, logic [11:0] a, logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= bcc_pkg::HTRANS_NONSEQ;
        haddr <= {20'h0, a};
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus
    task automatic set_cfg(logic en, logic [1:0] ptr);
        bus(1'b1, bcc_pkg::ADDR_UNLOCK_KEY, {24'h0, bcc_pkg::KEY_FIRST});
        bus(1'b1, bcc_pkg::ADDR_UNLOCK_KEY, {24'h0, bcc_pkg::KEY_SECOND});
        bus(1'b1, CFG, {16'h0, en, 2'b01, 3'h0, ptr, 8'h0});
        bus(1'b1, CFG, {16'h0, en, 2'b01, 3'h0, ptr, 8'h0});
    endtask : set_cfg
    task automatic ticks(int n);
        xtal_tick <= 1'b1;
        repeat (n) @(posedge hclk);
        xtal_tick <= 1'b0;
    endtask : ticks
    task automatic set_time(logic [15:0] y, logic [15:0] md, logic [15:0] wh, logic [15:0] ms);
        set_cfg(1'b0, bcc_pkg::PTR_YEAR);
        bus(1'b1, TV, {16'h0, y});
        bus(1'b1, TV, {16'h0, md});
        bus(1'b1, TV, {16'h0, wh});
        bus(1'b1, TV, {16'h0, ms});
    endtask : set_time
    task automatic rd_time(logic [15:0] y, logic [15:0] md, logic [15:0] wh, logic [15:0] ms);
        logic [15:0] e [4];
        logic [31:0] first [4];
        e = '{y, md, wh, ms};
        for (int p = 0; p < 2; p++) begin
            do begin
                bus(1'b0, CFG, 32'h0);
            end while (rd[12] !== 1'b0);
            bus(1'b1, CFG, 32'h0300);
            for (int i = 0; i < 4; i++) begin
                bus(1'b0, TV, 32'h0);
                if (p == 0) begin
                    first[i] = rd;
                end else begin
                    chk_word(rd, first[i]);
                end
                chk_word(rd, {16'h0, e[i]});
            end
        end
    endtask : rd_time
    task automatic run_second();
        set_cfg(1'b1, bcc_pkg::PTR_MIN_SEC);
        ticks(32735);
        bus(1'b0, CFG, 32'h0);
        chk_word(rd & 32'h1000, 32'h0);
        ticks(1);
        bus(1'b0, CFG, 32'h0);
        chk_word(rd & 32'h1000, 32'h1000);
        ticks(32);
    endtask : run_second
    function automatic logic [7:0] bcd_inc(logic [7:0] x);
        return (x[3:0] == 4'h9) ? {x[7:4] + 4'h1, 4'h0} : x + 8'h01;
    endfunction : bcd_inc
    function automatic logic [15:0] next_md(logic [7:0] y, logic [15:0] md);
        logic [7:0] last;
        last = 8'h31;
        if (md[15:8] inside {8'h04, 8'h06, 8'h09, 8'h11}) last = 8'h30;
        if (md[15:8] == 8'h02) last = ((y[7:4] * 10 + y[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
        if (md[7:0] != last) return {md[15:8], bcd_inc(md[7:0])};
        return (md[15:8] == 8'h12) ? 16'h0101 : {bcd_inc(md[15:8]), 8'h01};
    endfunction : next_md
    function automatic logic [31:0] amask(int i, logic [31:0] v);
        logic [15:0] m [3];
        m = '{bcc_pkg::MASK_MONTH_DAY, bcc_pkg::MASK_WEEKDAY_DIGIT_HOUR, bcc_pkg::MASK_MIN_SEC};
        return {16'h0, v[15:0] & m[i]};
    endfunction : amask
    initial begin
        repeat (100000) @(posedge hclk);
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b1, CFG, 32'h8000);
        bus(1'b1, bcc_pkg::ADDR_UNLOCK_KEY, {24'h0, bcc_pkg::KEY_FIRST});
        bus(1'b1, CFG, 32'h2000);
        bus(1'b0, CFG, 32'h0);
        chk_word(rd & 32'ha000, 32'h0);
        set_cfg(1'b0, bcc_pkg::PTR_MIN_SEC);
        bus(1'b0, CFG, 32'h0);
        chk_word(rd & 32'ha000, 32'h2000);
        bus(1'b1, 12'h020, 32'hffff_ffff);
        bus(1'b0, 12'h020, 32'h0);
        chk_word(rd, 32'h0);
        $display("done: unlock and decode");
        bus(1'b1, ACF, 32'h0200);
        for (int i = 0; i < 3; i++) begin
            al[i] = $random(seed);
            bus(1'b1, AV, al[i]);
        end
        bus(1'b1, ACF, 32'h0200);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, AV, 32'h0);
            chk_word(rd, amask((i > 2) ? 2 : i, al[(i > 2) ? 2 : i]));
        end
        bus(1'b1, CFG, 32'h0);
        bus(1'b1, ACF, 32'h0200);
        bus(1'b1, AV, ~al[0]);
        bus(1'b1, ACF, 32'h0200);
        bus(1'b0, AV, 32'h0);
        chk_word(rd, amask(0, al[0]));
        $display("done: alarm windows");
        set_time(16'h0099, 16'h1231, 16'h0623, 16'h5959);
        bus(1'b1, CFG, 32'h0300);
        bus(1'b1, TV, 32'h0055);
        rd_time(16'h0099, 16'h1231, 16'h0623, 16'h5959);
        run_second();
        rd_time(16'h0000, next_md(8'h99, 16'h1231), 16'h0000, 16'h0000);
        $display("done: year rollover");
        set_cfg(1'b1, bcc_pkg::PTR_MIN_SEC);
        ticks(1000);
        set_time(16'h0024, 16'h0228, 16'h0523, 16'h5959);
        bus(1'b1, ACF, 32'h0200);
        bus(1'b1, AV, 32'h0229);
        bus(1'b1, AV, 32'h0600);
        bus(1'b1, AV, 32'h0000);
        bus(1'b1, ACF, 32'h8000);
        chk_count(n_alarms, 0);
        run_second();
        rd_time(16'h0024, next_md(8'h24, 16'h0228), 16'h0600, 16'h0000);
        chk_count(n_alarms, 1);
        $display("done: leap day and alarm");
        complete_run();
    end
endmodule : bcd_clock_calendar_core_test
